/* verilog/irs_pkg.sv */
package irs_pkg;
  // clock rate
  localparam int unsigned CLK_HZ = 40_000_000;
  // wake interval (seconds per wake)
  localparam int unsigned WAKE_SEC_LONG = 8;
  localparam int unsigned SLOW_HZ_NOM = 10_000;
  localparam int unsigned REF_HZ = 32_768;
  localparam int unsigned CAL_SLOW_CYCLES = 10;
  // dividers of the interval after detections
  localparam int unsigned DIV_FIRST_SHIFT = 2;
  localparam int unsigned DIV_SECOND_SHIFT = 3;
  localparam int unsigned DETECT_ALARM = 3;
  // settle times
  localparam int unsigned SETTLE_US = 100;
  localparam int unsigned SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1_000_000) > 0) ?
    SETTLE_US * (CLK_HZ / 1_000_000) : 1;
  // buzzer pulse train, 1 ms period, half high
  localparam int unsigned BUZZ_PERIOD_US = 1000;
  localparam int unsigned BUZZ_HALF_CYC = BUZZ_PERIOD_US * (CLK_HZ / 1_000_000) / 2;
  // samples per emitter state
  localparam int unsigned N_SAMPLES = 4;
  localparam int unsigned AVG_SHIFT = 2;
  localparam int unsigned ADC_W = 10;
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_IRQ_ST = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
  localparam logic [7:0] ADDR_DARK = 8'h10;
  localparam logic [7:0] ADDR_LIGHT = 8'h14;
  localparam logic [7:0] ADDR_INTV = 8'h18;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0040;
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_THR_LSB = 4;
  localparam int unsigned CTRL_THR_W = 10;
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_MEAS = 0;
  localparam int unsigned IRQ_DET = 1;
  localparam int unsigned IRQ_ALARM = 2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [2:0] {S_IDLE, S_CAL, S_SETTLE, S_SAMPLE, S_DECIDE} irs_state_t;
endpackage

/* verilog/irs_sequencer.sv */
`timescale 1ns/1ps
module irs_sequencer
  import irs_pkg::*;
#(
  parameter int unsigned INTV_W = 20,
  parameter int unsigned CNT_W = 24,
  // reference rate, nominal slow rate and settle length; scaled down only for quick runs
  parameter int unsigned REF_HZ_P = irs_pkg::REF_HZ,
  parameter int unsigned SLOW_HZ_P = irs_pkg::SLOW_HZ_NOM,
  parameter int unsigned SETTLE_P = irs_pkg::SETTLE_CYC
)
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // oscillator and button pins
  input wire logic SLOW_OSC_I,
  input wire logic REF_OSC_I,
  input wire logic BUTTON_N_I,
  // converter
  output logic ADC_START_O,
  input wire logic ADC_DONE_I,
  input wire logic [irs_pkg::ADC_W-1:0] ADC_DATA_I,
  // front end and outputs
  output logic AMP_CTIV_EN_O,
  output logic AMP_GAIN_EN_O,
  output logic IR_LED_O,
  output logic ALARM_O,
  output logic BUZZER_EN_O,
  output logic IRQ_O,
  // axi4-lite slave
  input wire logic [7:0] AWADDR_I,
  input wire logic AWVALID_I,
  output logic AWREADY_O,
  input wire logic [31:0] WDATA_I,
  input wire logic [3:0] WSTRB_I,
  input wire logic WVALID_I,
  output logic WREADY_O,
  output logic [1:0] BRESP_O,
  output logic BVALID_O,
  input wire logic BREADY_I,
  input wire logic [7:0] ARADDR_I,
  input wire logic ARVALID_I,
  output logic ARREADY_O,
  output logic [31:0] RDATA_O,
  output logic [1:0] RRESP_O,
  output logic RVALID_O,
  input wire logic RREADY_I
);
  import irs_pkg::*;

  // refuse sizes that the interval and settle counters cannot hold
  if (INTV_W < 8 || CNT_W < 16 || SETTLE_P < 1 || SETTLE_P > 16'hFFFF ||
      $clog2(WAKE_SEC_LONG * SLOW_HZ_P + 1) > INTV_W)
  begin : g_param_check
    $error("irs_sequencer: parameters out of range");
  end

  irs_state_t state_reg;
  logic [2:0] slow_sync_reg, ref_sync_reg, btn_sync_reg;
  logic slow_lvl_reg, ref_lvl_reg, btn_lvl_reg;
  logic slow_tick, ref_tick, btn_press;
  logic [INTV_W-1:0] wake_interval_count_reg, base_interval_reg, wake_cnt_reg;
  logic [CNT_W-1:0] ref_cnt_reg;
  logic [3:0] cal_slow_reg;
  logic [15:0] settle_reg;
  logic light_phase_reg;
  logic [2:0] nsamp_reg;
  logic [ADC_W+1:0] acc_reg;
  logic [ADC_W-1:0] dark_reg, light_reg;
  logic [1:0] det_reg;
  logic alarm_reg;
  logic [15:0] buzz_cnt_reg;
  logic buzz_reg;
  logic [31:0] ctrl_reg;
  logic [IRQ_W-1:0] irq_st_reg, irq_mask_reg, irq_set;
  logic wake, reflect;
  logic aw_ok_reg, w_ok_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;

  // three-stage pin synchronisers; change counts once stages 2 and 3 agree
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      slow_sync_reg <= 3'b000;
      ref_sync_reg <= 3'b000;
      btn_sync_reg <= 3'b111;
      slow_lvl_reg <= 1'b0;
      ref_lvl_reg <= 1'b0;
      btn_lvl_reg <= 1'b1;
    end
    else
    begin
      slow_sync_reg <= {slow_sync_reg[1:0], SLOW_OSC_I};
      ref_sync_reg <= {ref_sync_reg[1:0], REF_OSC_I};
      btn_sync_reg <= {btn_sync_reg[1:0], BUTTON_N_I};
      if (slow_sync_reg[1] == slow_sync_reg[2])
        slow_lvl_reg <= slow_sync_reg[2];
      if (ref_sync_reg[1] == ref_sync_reg[2])
        ref_lvl_reg <= ref_sync_reg[2];
      if (btn_sync_reg[1] == btn_sync_reg[2])
        btn_lvl_reg <= btn_sync_reg[2];
    end
  end

  // rising edges of the filtered levels; button is active low
  assign slow_tick = (slow_sync_reg[1] == slow_sync_reg[2]) && slow_sync_reg[2] && !slow_lvl_reg;
  assign ref_tick = (ref_sync_reg[1] == ref_sync_reg[2]) && ref_sync_reg[2] && !ref_lvl_reg;
  assign btn_press = (btn_sync_reg[1] == btn_sync_reg[2]) && !btn_sync_reg[2] && btn_lvl_reg;

  // wake counter runs on slow ticks only in idle
  assign wake = (state_reg == S_IDLE) && slow_tick && (wake_cnt_reg >= wake_interval_count_reg) && ctrl_reg[CTRL_EN_BIT];

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      wake_cnt_reg <= '0;
    else if (state_reg != S_IDLE || wake)
      wake_cnt_reg <= '0;
    else if (slow_tick)
      wake_cnt_reg <= wake_cnt_reg + 1'b1;
  end

  // averaged readings, shift in place of division
  assign reflect = (light_reg > dark_reg) &&
    ((light_reg - dark_reg) > ctrl_reg[CTRL_THR_LSB +: CTRL_THR_W]);

  // main sequencer
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      state_reg <= S_IDLE;
      ref_cnt_reg <= '0;
      cal_slow_reg <= '0;
      settle_reg <= '0;
      light_phase_reg <= 1'b0;
      nsamp_reg <= '0;
      acc_reg <= '0;
      dark_reg <= '0;
      light_reg <= '0;
    end
    else
    begin
      unique case (state_reg)
        S_IDLE:
        begin
          if (wake)
          begin
            state_reg <= S_CAL;
            ref_cnt_reg <= '0;
            cal_slow_reg <= '0;
          end
        end
        S_CAL:
        begin
          // count reference edges across a fixed number of slow cycles
          if (ref_tick)
            ref_cnt_reg <= ref_cnt_reg + 1'b1;
          if (slow_tick)
          begin
            if (cal_slow_reg == 4'(CAL_SLOW_CYCLES - 1))
            begin
              state_reg <= S_SETTLE;
              settle_reg <= 16'(SETTLE_P);
              light_phase_reg <= 1'b0;
            end
            cal_slow_reg <= cal_slow_reg + 1'b1;
          end
        end
        S_SETTLE:
        begin
          if (settle_reg == 16'd1)
          begin
            state_reg <= S_SAMPLE;
            nsamp_reg <= '0;
            acc_reg <= '0;
          end
          settle_reg <= settle_reg - 1'b1;
        end
        S_SAMPLE:
        begin
          if (ADC_DONE_I)
          begin
            acc_reg <= acc_reg + (ADC_W+2)'(ADC_DATA_I);
            nsamp_reg <= nsamp_reg + 1'b1;
            if (nsamp_reg == 3'(N_SAMPLES - 1))
            begin
              if (!light_phase_reg)
              begin
                dark_reg <= ADC_W'((acc_reg + (ADC_W+2)'(ADC_DATA_I)) >> AVG_SHIFT);
                light_phase_reg <= 1'b1;
                settle_reg <= 16'(SETTLE_P);
                state_reg <= S_SETTLE;
              end
              else
              begin
                light_reg <= ADC_W'((acc_reg + (ADC_W+2)'(ADC_DATA_I)) >> AVG_SHIFT);
                state_reg <= S_DECIDE;
              end
            end
          end
        end
        S_DECIDE:
          state_reg <= S_IDLE;
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // converter start: one pulse per sample while sampling
  logic adc_busy_reg;
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      adc_busy_reg <= 1'b0;
    else if (state_reg != S_SAMPLE || ADC_DONE_I)
      adc_busy_reg <= 1'b0;
    else if (ADC_START_O)
      adc_busy_reg <= 1'b1;
  end
  assign ADC_START_O = (state_reg == S_SAMPLE) && !adc_busy_reg && !ADC_DONE_I;

  // amps powered only from settling to end of sampling
  assign AMP_CTIV_EN_O = (state_reg == S_SETTLE) || (state_reg == S_SAMPLE);
  assign AMP_GAIN_EN_O = AMP_CTIV_EN_O;
  assign IR_LED_O = AMP_CTIV_EN_O && light_phase_reg;

  // interval, detection count and alarm
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      base_interval_reg <= INTV_W'(WAKE_SEC_LONG * SLOW_HZ_P);
      wake_interval_count_reg <= INTV_W'(WAKE_SEC_LONG * SLOW_HZ_P);
      det_reg <= '0;
      alarm_reg <= 1'b0;
    end
    else
    begin
      if (state_reg == S_CAL && slow_tick && cal_slow_reg == 4'(CAL_SLOW_CYCLES - 1))
      begin
        // slow freq = REF_HZ*CAL/(ref_cnt+1); cycles in 8 s, floor
        base_interval_reg <= INTV_W'(((REF_HZ_P * CAL_SLOW_CYCLES * WAKE_SEC_LONG) / (ref_cnt_reg + 1'b1)));
      end
      if (btn_press && alarm_reg)
      begin
        alarm_reg <= 1'b0;
        det_reg <= '0;
        wake_interval_count_reg <= base_interval_reg;
      end
      else if (state_reg == S_DECIDE)
      begin
        if (reflect)
        begin
          if (det_reg == 2'd0)
            wake_interval_count_reg <= base_interval_reg >> DIV_FIRST_SHIFT;
          else
            wake_interval_count_reg <= base_interval_reg >> DIV_SECOND_SHIFT;
          if (det_reg == 2'(DETECT_ALARM - 1))
            alarm_reg <= 1'b1;
          else if (det_reg < 2'(DETECT_ALARM - 1))
            det_reg <= det_reg + 1'b1;
        end
        else if (!alarm_reg)
        begin
          det_reg <= '0;
          wake_interval_count_reg <= base_interval_reg;
        end
      end
    end
  end
  assign ALARM_O = alarm_reg;

  // buzzer square wave, 1 ms period at half duty
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      buzz_cnt_reg <= '0;
      buzz_reg <= 1'b0;
    end
    else if (!alarm_reg)
    begin
      buzz_cnt_reg <= '0;
      buzz_reg <= 1'b0;
    end
    else if (buzz_cnt_reg == 16'(BUZZ_HALF_CYC - 1))
    begin
      buzz_cnt_reg <= '0;
      buzz_reg <= !buzz_reg;
    end
    else
      buzz_cnt_reg <= buzz_cnt_reg + 1'b1;
  end
  assign BUZZER_EN_O = buzz_reg;

  // interrupt events; set wins over read-clear
  assign irq_set = {(state_reg == S_DECIDE) && reflect && det_reg == 2'(DETECT_ALARM - 1) && !alarm_reg,
                    (state_reg == S_DECIDE) && reflect,
                    (state_reg == S_DECIDE)};
  logic rd_stat_take;
  assign rd_stat_take = ARVALID_I && ARREADY_O && ARADDR_I == ADDR_IRQ_ST;
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      irq_st_reg <= '0;
    else
      irq_st_reg <= (rd_stat_take ? '0 : irq_st_reg) | irq_set;
  end
  assign IRQ_O = |(irq_st_reg & irq_mask_reg);

  // axi write: address and data in either order, response after both
  assign AWREADY_O = !aw_ok_reg && !BVALID_O;
  assign WREADY_O = !w_ok_reg && !BVALID_O;
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      aw_ok_reg <= 1'b0;
      w_ok_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= '0;
      BVALID_O <= 1'b0;
      BRESP_O <= RESP_OKAY;
      ctrl_reg <= CTRL_RESET;
      irq_mask_reg <= '0;
    end
    else
    begin
      if (AWVALID_I && AWREADY_O)
      begin
        aw_ok_reg <= 1'b1;
        awaddr_reg <= AWADDR_I;
      end
      if (WVALID_I && WREADY_O)
      begin
        w_ok_reg <= 1'b1;
        wdata_reg <= WDATA_I;
      end
      if (aw_ok_reg && w_ok_reg)
      begin
        aw_ok_reg <= 1'b0;
        w_ok_reg <= 1'b0;
        BVALID_O <= 1'b1;
        BRESP_O <= RESP_OKAY;
        if (awaddr_reg == ADDR_CTRL)
          ctrl_reg <= wdata_reg;
        else if (awaddr_reg == ADDR_IRQ_MASK)
          irq_mask_reg <= wdata_reg[IRQ_W-1:0];
        else if (!(awaddr_reg inside {ADDR_STAT, ADDR_IRQ_ST, ADDR_DARK, ADDR_LIGHT, ADDR_INTV}))
          BRESP_O <= RESP_SLVERR;
      end
      else if (BVALID_O && BREADY_I)
        BVALID_O <= 1'b0;
    end
  end

  // axi read: one-cycle answer from registered data
  assign ARREADY_O = !RVALID_O;
  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      RVALID_O <= 1'b0;
      RDATA_O <= '0;
      RRESP_O <= RESP_OKAY;
    end
    else if (ARVALID_I && ARREADY_O)
    begin
      RVALID_O <= 1'b1;
      RRESP_O <= RESP_OKAY;
      unique case (ARADDR_I)
        ADDR_CTRL: RDATA_O <= ctrl_reg;
        ADDR_STAT: RDATA_O <= 32'({alarm_reg, det_reg, state_reg});
        ADDR_IRQ_ST: RDATA_O <= 32'(irq_st_reg | irq_set);
        ADDR_IRQ_MASK: RDATA_O <= 32'(irq_mask_reg);
        ADDR_DARK: RDATA_O <= 32'(dark_reg);
        ADDR_LIGHT: RDATA_O <= 32'(light_reg);
        ADDR_INTV: RDATA_O <= 32'(wake_interval_count_reg);
        default:
        begin
          RDATA_O <= '0;
          RRESP_O <= RESP_SLVERR;
        end
      endcase
    end
    else if (RREADY_I)
      RVALID_O <= 1'b0;
  end

  // amps must be off whenever idle
  a_amp_idle_off: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state_reg == S_IDLE) |-> !AMP_CTIV_EN_O && !AMP_GAIN_EN_O && !IR_LED_O) else $error("amp on in idle");
  a_led_dark_first: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(AMP_CTIV_EN_O) |-> !IR_LED_O) else $error("led on during dark");
  a_wake_leaves_idle: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    wake |=> state_reg == S_CAL) else $error("wake not taken");
  a_alarm_needs_three: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    $rose(alarm_reg) |-> $past(det_reg) == 2'd2) else $error("alarm early");
  a_first_div_four: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state_reg == S_DECIDE && reflect && det_reg == 2'd0 && !(btn_press && alarm_reg))
    |=> wake_interval_count_reg == (base_interval_reg >> 2)) else $error("interval not /4");
  a_second_div_eight: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state_reg == S_DECIDE && reflect && det_reg == 2'd1 && !(btn_press && alarm_reg))
    |=> wake_interval_count_reg == (base_interval_reg >> 3)) else $error("interval not /8");
  a_button_clears: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (btn_press && alarm_reg) |=> !alarm_reg && det_reg == 2'd0) else $error("button ignored");
  a_buzz_quiet: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !alarm_reg |=> !buzz_reg) else $error("buzzer without alarm");
  a_miss_resets: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    (state_reg == S_DECIDE && !reflect && !alarm_reg) |=> det_reg == 2'd0) else $error("count kept");
endmodule

/* verif/irs_adc_model.sv */
`timescale 1ns/1ps
module irs_adc_model
  import irs_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // converter handshake
  input wire logic start_i,
  output logic done_o,
  output logic [ADC_W-1:0] data_o,
  // front end seen at each sample
  input wire logic led_i,
  input wire logic amp_i,
  input wire logic [8*ADC_W-1:0] vals_i,
  output logic [7:0] led_o,
  output int settle_o
);
  int idx;
  int lat;
  int since;
  logic busy;
  logic led_d;
  // one conversion per request, latency alternates prompt and slow
  always @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      done_o <= 1'b0;
      data_o <= '0;
      led_o <= '0;
      settle_o <= 32'h7FFF_FFFF;
      idx <= 0;
      lat <= 0;
      since <= 0;
      busy <= 1'b0;
      led_d <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      data_o <= ~data_o; // nothing valid, so the bus keeps changing
      led_d <= led_i;
      since <= (!amp_i || led_i != led_d) ? 0 : since + 1;
      if (busy && lat == 0)
      begin
        done_o <= 1'b1;
        data_o <= vals_i[(idx % 8) * ADC_W +: ADC_W];
        led_o[idx % 8] <= led_i;
        busy <= 1'b0;
        idx <= idx + 1;
      end
      else if (busy)
        lat <= lat - 1;
      else if (start_i && !done_o)
      begin
        busy <= 1'b1;
        lat <= (idx % 2) * 3;
        // shortest settle seen before a phase's first sample
        if (idx % 4 == 0 && since < settle_o)
          settle_o <= since;
      end
    end
  end
endmodule

/* verif/tb.sv */
`timescale 1ns/1ps
module tb;
  import irs_pkg::*;
  // scaled rates keep wakes a few thousand cycles apart
  localparam int REF_HZ_TB = 64;
  localparam int SLOW_HZ_TB = 16;
  localparam int SETTLE_TB = 200;
  localparam int K = REF_HZ_TB * CAL_SLOW_CYCLES * WAKE_SEC_LONG;
  localparam int LO = K / 22;
  localparam int HI = K / 20;
  logic CLK_I = 0, NRST_I = 0, SLOW_OSC_I = 0, REF_OSC_I = 0, BUTTON_N_I = 1;
  logic ADC_START_O, ADC_DONE_I, AMP_CTIV_EN_O, AMP_GAIN_EN_O, IR_LED_O;
  logic ALARM_O, BUZZER_EN_O, IRQ_O;
  logic [ADC_W-1:0] ADC_DATA_I;
  logic [7:0] AWADDR_I = 0, ARADDR_I = 0;
  logic [31:0] WDATA_I = 0, RDATA_O, rdat;
  logic [3:0] WSTRB_I = 4'hF;
  logic AWVALID_I = 0, WVALID_I = 0, BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
  logic [1:0] BRESP_O, RRESP_O, rsp;
  logic [8*ADC_W-1:0] vals = 0;
  logic [7:0] led_h;
  logic [31:0] cyc = 0;
  int settle, seed, errors, check_count, wk, gap, cnt, sh, psh, t;
  irs_sequencer #(.REF_HZ_P(REF_HZ_TB), .SLOW_HZ_P(SLOW_HZ_TB), .SETTLE_P(SETTLE_TB)) dut (.CLK_I, .NRST_I,
    .SLOW_OSC_I, .REF_OSC_I, .BUTTON_N_I, .ADC_START_O, .ADC_DONE_I,
    .ADC_DATA_I, .AMP_CTIV_EN_O, .AMP_GAIN_EN_O, .IR_LED_O, .ALARM_O, .BUZZER_EN_O, .IRQ_O, .AWADDR_I,
    .AWVALID_I, .AWREADY_O, .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O, .BREADY_I,
    .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O, .RVALID_O, .RREADY_I);
  irs_adc_model adc (.clk_i(CLK_I), .nrst_i(NRST_I), .start_i(ADC_START_O), .done_o(ADC_DONE_I),
    .data_o(ADC_DATA_I), .led_i(IR_LED_O), .amp_i(AMP_CTIV_EN_O & AMP_GAIN_EN_O), .vals_i(vals),
    .led_o(led_h), .settle_o(settle));
  // 40 MHz clock
  always #12.5 CLK_I = ~CLK_I;
  // oscillators sped up: slow every 8 cycles, reference every 4
  always @(posedge CLK_I)
  begin
    cyc <= cyc + 1;
    SLOW_OSC_I <= cyc[2];
    REF_OSC_I <= cyc[1];
  end
  // spacing of wakes, seen at amplifier turn-on
  always @(posedge AMP_CTIV_EN_O)
  begin
    gap = cyc - wk;
    wk = cyc;
  end
  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cr(input logic [31:0] g, input int lo, input int hi);
    check_count++;
    if (g >= lo && g <= hi)
      ;
    else
    begin
      errors++;
      $display("unexpected at %0t got %h exp %h..%h", $time, g, lo, hi);
    end
  endtask
  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    b = 0;
    n = 0;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= d;
    AWVALID_I <= 1'b1;
    WVALID_I <= 1'b1;
    BREADY_I <= 1'b1;
    while (b !== 1'b1 && n < 50)
    begin
      @(negedge CLK_I);
      aw = AWVALID_I & AWREADY_O;
      w = WVALID_I & WREADY_O;
      b = BVALID_O & BREADY_I;
      rsp = BRESP_O;
      @(posedge CLK_I);
      if (aw)
        AWVALID_I <= 1'b0;
      if (w)
        WVALID_I <= 1'b0;
      if (b)
        BREADY_I <= 1'b0;
      n++;
    end
    ck(b, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, r;
    int n;
    r = 0;
    n = 0;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1'b1;
    RREADY_I <= 1'b1;
    while (r !== 1'b1 && n < 50)
    begin
      @(negedge CLK_I);
      ar = ARVALID_I & ARREADY_O;
      r = RVALID_O & RREADY_I;
      rdat = RDATA_O;
      rsp = RRESP_O;
      @(posedge CLK_I);
      if (ar)
        ARVALID_I <= 1'b0;
      if (r)
        RREADY_I <= 1'b0;
      n++;
    end
    ck(r, 1'b1);
  endtask
  // one measurement against the reference model of the sequence
  task automatic meas(input logic dt, input int id);
    int d, l, k, rise;
    logic [9:0] x;
    d = 0;
    l = 0;
    for (k = 0; k < 8; k++)
    begin
      x = 10'({$random(seed)} % 64 + 100 + ((k > 3 && dt) ? 400 : 0));
      vals[k*ADC_W +: ADC_W] = x;
      if (k < 4)
        d += x;
      else
        l += x;
    end
    d = d >> AVG_SHIFT;
    l = l >> AVG_SHIFT;
    rise = 0;
    // threshold 100 written into the control register
    if (l - d > 100)
    begin
      cnt++;
      rise = (cnt == DETECT_ALARM);
      sh = (cnt == 1) ? DIV_FIRST_SHIFT : DIV_SECOND_SHIFT;
    end
    else if (cnt < DETECT_ALARM)
    begin
      cnt = 0;
      sh = 0;
    end
    @(negedge AMP_CTIV_EN_O);
    repeat (5) @(posedge CLK_I);
    if (psh >= 0)
      cr(gap, (LO >> psh) * 8, (HI >> psh) * 8 + 2 * SETTLE_TB + 400);
    psh = sh;
    ck(AMP_CTIV_EN_O | AMP_GAIN_EN_O | IR_LED_O, 0);
    ck(led_h, 8'hF0);
    ck(IRQ_O, 0);
    wr(ADDR_IRQ_MASK, 32'h0000_0007);
    repeat (2) @(posedge CLK_I);
    ck(IRQ_O, 1);
    rd(ADDR_IRQ_ST);
    ck(rdat, {rise[0], dt, 1'b1});
    wr(ADDR_IRQ_MASK, 32'h0000_0000);
    rd(ADDR_IRQ_ST);
    ck(rdat, 0);
    rd(ADDR_DARK);
    ck(rdat, d);
    rd(ADDR_LIGHT);
    ck(rdat, l);
    ck(ALARM_O, cnt >= DETECT_ALARM);
    rd(ADDR_INTV);
    cr(rdat, LO >> sh, HI >> sh);
    $display("test %0d done", id);
  endtask
  task conclude;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog: six wakes and the buzzer periods need about 70k cycles
  initial
  begin
    #2_500_000;
    errors++;
    conclude;
  end
  // main sequence
  initial
  begin
    seed = 99514;
    psh = -1;
    repeat (5) @(posedge CLK_I);
    NRST_I <= 1'b1;
    rd(ADDR_CTRL);
    ck(rdat, CTRL_RESET);
    rd(ADDR_IRQ_MASK);
    ck(rdat, 0);
    ck(ALARM_O | BUZZER_EN_O | IRQ_O | ADC_START_O, 0);
    rd(8'h1C);
    ck(rsp, RESP_SLVERR);
    ck(rdat, 0);
    wr(8'h20, 32'h0000_0001);
    ck(rsp, RESP_SLVERR);
    wr(ADDR_DARK, 32'h0000_0155);
    ck(rsp, RESP_OKAY);
    rd(ADDR_DARK);
    ck(rdat, 0);
    wr(ADDR_CTRL, 32'h0000_0641);
    $display("test 0 done");
    for (t = 0; t < 6; t++)
      meas(6'b111010 >> t, t + 1);
    ck(BUZZER_EN_O === 1'b1 || BUZZER_EN_O === 1'b0, 1);
    @(posedge BUZZER_EN_O);
    t = cyc;
    @(negedge BUZZER_EN_O);
    cr(cyc - t, BUZZ_HALF_CYC - 1, BUZZ_HALF_CYC + 1);
    @(posedge BUZZER_EN_O);
    cr(cyc - t, 2 * BUZZ_HALF_CYC - 1, 2 * BUZZ_HALF_CYC + 1);
    @(posedge CLK_I);
    BUTTON_N_I <= 1'b0;
    repeat (10) @(posedge CLK_I);
    BUTTON_N_I <= 1'b1;
    repeat (10) @(posedge CLK_I);
    ck(ALARM_O | BUZZER_EN_O, 0);
    rd(ADDR_INTV);
    cr(rdat, LO, HI);
    cr(settle, SETTLE_TB - 2, 32'h7FFF_FFFF);
    $display("test 7 done");
    conclude;
  end
endmodule
